// >>> esm_pad_partner.sv
// pad partner: outside drivers, pull-ups and floating lines around the pins
`timescale 1ns/1ps
module esm_pad_partner #(parameter int N = 4) (
    input wire logic clk,
    input wire logic [N-1:0] pad_out,
    input wire logic [N-1:0] pad_oe_n,
    input wire logic [N-1:0] pad_pullup,
    input wire logic [N-1:0] ext_en,
    input wire logic [N-1:0] ext_val,
    output logic [N-1:0] pad_in
);
    logic [N-1:0] last = '0;
    always_ff @(posedge clk) begin
        last <= pad_in;
    end
    // a floating line without pull-up shows the inverse of its last level
    always_comb begin
        for (int i = 0; i < N; i++) begin
            if (!pad_oe_n[i]) begin
                pad_in[i] = pad_out[i];
            end else if (ext_en[i]) begin
                pad_in[i] = ext_val[i];
            end else begin
                pad_in[i] = pad_pullup[i] | ~last[i];
            end
        end
    end
endmodule

// >>> esm_pin_mux.sv
// pin multiplexer for port c lines 4..7 and port e lines 4..5
//
// Behaviour
// - gpio pins individually set as input or output
// - reset selects decoder 0 on port c 4..7
// - reset selects spi0 clock and mosi on e4/e5
// - clearing port c pull-up bit disables pull-up
// - clearing port e pull-up bit disables pull-up
// - alternate function: timer a channels 0..3
// - spi clock output as master, input as slave
// - mosi output on master, input on slave
`timescale 1ns/1ps
module esm_pin_mux
    import esm_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    // software settings
    input wire logic [1:0] portc_mode_sel,
    input wire logic [3:0] portc_gpio_sel,
    input wire logic [1:0] porte_gpio_sel,
    input wire logic pur_write,
    input wire logic [7:0] portc_pullup_enable_wdata,
    input wire logic [7:0] porte_pullup_enable_wdata,
    input wire esm_gpio_t portc_gpio,
    input wire esm_gpio_t porte_gpio,
    input wire logic spi0_master,
    // pads
    input wire logic [3:0] portc_pad_in,
    input wire logic [1:0] porte_pad_in,
    output logic [3:0] portc_pad_out,
    output logic [3:0] portc_pad_oe_n,
    output logic [3:0] portc_pad_pullup,
    output logic [1:0] porte_pad_out,
    output logic [1:0] porte_pad_oe_n,
    output logic [1:0] porte_pad_pullup,
    // peripheral side
    output logic decoder0_phase_a,
    output logic decoder0_phase_b,
    output logic decoder0_index_pulse,
    output logic decoder0_home_switch,
    input wire esm_pad_t [3:0] timer_a_chan,
    output logic [3:0] timer_a_in,
    input wire logic spi0_clock_out,
    input wire logic spi0_mosi_out,
    output logic spi0_serial_clock,
    output logic spi0_master_out_line,
    output logic [3:0] portc_gpio_in,
    output logic [1:0] porte_gpio_in
);
    // ============================================================
    // pad synchronisers
    logic [3:0] c_s1;
    logic [3:0] c_s2;
    logic [1:0] e_s1;
    logic [1:0] e_s2;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            c_s1 <= 4'h0;
            c_s2 <= 4'h0;
            e_s1 <= 2'h0;
            e_s2 <= 2'h0;
        end else begin
            c_s1 <= portc_pad_in;
            c_s2 <= c_s1;
            e_s1 <= porte_pad_in;
            e_s2 <= e_s1;
        end
    end

    // ============================================================
    // function selection registers
    logic [3:0] c_fsel;
    logic [1:0] e_fsel;
    logic [1:0] c_mode;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            c_fsel <= ESM_FSEL_C_RST;
            e_fsel <= ESM_FSEL_E_RST;
            c_mode <= ESM_CMODE_QDEC;
        end else begin
            c_fsel <= ~portc_gpio_sel;
            e_fsel <= ~porte_gpio_sel;
            c_mode <= portc_mode_sel;
        end
    end

    // ============================================================
    // pull-up enables, held until software rewrites them
    logic [7:0] c_pur;
    logic [7:0] e_pur;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            c_pur <= ESM_PUR_C_RST;
            e_pur <= ESM_PUR_E_RST;
        end else if (pur_write) begin
            c_pur <= portc_pullup_enable_wdata;
            e_pur <= porte_pullup_enable_wdata;
        end
    end

    // ============================================================
    // port c: decoder inputs, timer channels or gpio
    logic [3:0] next_c_out;
    logic [3:0] next_c_oe_n;

    always_comb begin
        for (int i = 0; i < ESM_NC; i++) begin
            if (!c_fsel[i]) begin
                next_c_out[i] = portc_gpio.data[i];
                next_c_oe_n[i] = ~portc_gpio.dir[i];
            end else if (c_mode == ESM_CMODE_TMR) begin
                next_c_out[i] = timer_a_chan[i].dout;
                next_c_oe_n[i] = timer_a_chan[i].oe_n;
            end else begin
                // decoder inputs only: gpio direction is ignored
                next_c_out[i] = 1'b0;
                next_c_oe_n[i] = 1'b1;
            end
        end
    end

    logic c_qdec;
    assign c_qdec = (c_mode != ESM_CMODE_TMR);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            portc_pad_out <= 4'h0;
            portc_pad_oe_n <= 4'hF;
            portc_pad_pullup <= 4'hF;
            decoder0_phase_a <= 1'b0;
            decoder0_phase_b <= 1'b0;
            decoder0_index_pulse <= 1'b0;
            decoder0_home_switch <= 1'b0;
            timer_a_in <= 4'h0;
            portc_gpio_in <= 4'h0;
        end else begin
            portc_pad_out <= next_c_out;
            portc_pad_oe_n <= next_c_oe_n;
            portc_pad_pullup <= c_pur[ESM_PC_LSB +: ESM_NC];
            decoder0_phase_a <= c_fsel[0] & c_qdec & c_s2[0];
            decoder0_phase_b <= c_fsel[1] & c_qdec & c_s2[1];
            decoder0_index_pulse <= c_fsel[2] & c_qdec & c_s2[2];
            decoder0_home_switch <= c_fsel[3] & c_qdec & c_s2[3];
            timer_a_in <= c_fsel & {4{~c_qdec}} & c_s2;
            portc_gpio_in <= c_s2;
        end
    end

    // ============================================================
    // port e: spi0 clock and mosi or gpio
    logic [1:0] next_e_out;
    logic [1:0] next_e_oe_n;

    always_comb begin
        for (int i = 0; i < ESM_NE; i++) begin
            if (!e_fsel[i]) begin
                next_e_out[i] = porte_gpio.data[i];
                next_e_oe_n[i] = ~porte_gpio.dir[i];
            end else begin
                next_e_out[i] = (i == 0) ? spi0_clock_out : spi0_mosi_out;
                next_e_oe_n[i] = ~spi0_master;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            porte_pad_out <= 2'h0;
            porte_pad_oe_n <= 2'h3;
            porte_pad_pullup <= 2'h3;
            spi0_serial_clock <= 1'b0;
            spi0_master_out_line <= 1'b0;
            porte_gpio_in <= 2'h0;
        end else begin
            porte_pad_out <= next_e_out;
            porte_pad_oe_n <= next_e_oe_n;
            porte_pad_pullup <= e_pur[ESM_PE_LSB +: ESM_NE];
            // as slave the pad feeds the engine; as master the engine's own value loops back
            spi0_serial_clock <= e_fsel[0] & (spi0_master ? spi0_clock_out : e_s2[0]);
            spi0_master_out_line <= e_fsel[1] & (spi0_master ? spi0_mosi_out : e_s2[1]);
            porte_gpio_in <= e_s2;
        end
    end

    // ============================================================
    // checks
    a_pullup_reset_value: assert property (@(posedge clk)
        $fell(sys_rst) |-> portc_pad_pullup == 4'hF && porte_pad_pullup == 2'h3)
        else $error("pull-ups not enabled after reset");
    a_portc_pullup_follow: assert property (@(posedge clk) disable iff (sys_rst)
        pur_write ##2 1 |-> portc_pad_pullup == $past(portc_pullup_enable_wdata[7:4], 2))
        else $error("port c pull-up mismatch");
    a_porte_pullup_follow: assert property (@(posedge clk) disable iff (sys_rst)
        pur_write ##2 1 |-> porte_pad_pullup == $past(porte_pullup_enable_wdata[5:4], 2))
        else $error("port e pull-up mismatch");
    a_reset_pads_input: assert property (@(posedge clk)
        $fell(sys_rst) |-> portc_pad_oe_n == 4'hF)
        else $error("port c drives after reset");
    a_qdec_never_drives: assert property (@(posedge clk) disable iff (sys_rst)
        (c_fsel[0] && c_qdec) |=> portc_pad_oe_n[0])
        else $error("decoder pin driven");
    a_gpio_dir_out: assert property (@(posedge clk) disable iff (sys_rst)
        (!c_fsel[1] && portc_gpio.dir[1]) |=> !portc_pad_oe_n[1])
        else $error("gpio output not driven");
    a_porte_gpio_out: assert property (@(posedge clk) disable iff (sys_rst)
        (!e_fsel[1] && porte_gpio.dir[1]) |=> !porte_pad_oe_n[1])
        else $error("port e gpio output not driven");
    a_timer_drive: assert property (@(posedge clk) disable iff (sys_rst)
        (c_fsel[2] && !c_qdec) |=> portc_pad_oe_n[2] == $past(timer_a_chan[2].oe_n))
        else $error("timer enable not routed");
    a_sclk_master_out: assert property (@(posedge clk) disable iff (sys_rst)
        (e_fsel[0] && spi0_master) |=> !porte_pad_oe_n[0])
        else $error("spi clock not driven as master");
    a_sclk_slave_in: assert property (@(posedge clk) disable iff (sys_rst)
        (e_fsel[0] && !spi0_master) |=> porte_pad_oe_n[0])
        else $error("spi clock driven as slave");
    a_mosi_slave_in: assert property (@(posedge clk) disable iff (sys_rst)
        (e_fsel[1] && !spi0_master) |=> porte_pad_oe_n[1])
        else $error("mosi driven as slave");
    a_mosi_master_out: assert property (@(posedge clk) disable iff (sys_rst)
        (e_fsel[1] && spi0_master) |=> porte_pad_out[1] == $past(spi0_mosi_out))
        else $error("mosi not routed as master");
    a_spi_reset_sel: assert property (@(posedge clk)
        $fell(sys_rst) |-> e_fsel == 2'h3)
        else $error("spi not selected after reset");
endmodule

// >>> esm_pkg.sv
// package for the encoder and spi pin multiplexer: field positions, reset values, carriers
package esm_pkg;
    localparam int ESM_NC = 4;
    localparam int ESM_NE = 2;
    localparam int ESM_PC_LSB = 4;
    localparam int ESM_PE_LSB = 4;
    localparam logic [7:0] ESM_PUR_C_RST = 8'hF0;
    localparam logic [7:0] ESM_PUR_E_RST = 8'h30;
    localparam logic [3:0] ESM_FSEL_C_RST = 4'hF;
    localparam logic [1:0] ESM_FSEL_E_RST = 2'h3;
    localparam logic [1:0] ESM_CMODE_QDEC = 2'h0;
    localparam logic [1:0] ESM_CMODE_TMR = 2'h1;
    localparam logic [1:0] ESM_CMODE_GPIO = 2'h3;

    // one carrier per pad: input, output, output enable (low = driving)
    typedef struct packed {
        logic din;
        logic dout;
        logic oe_n;
    } esm_pad_t;

    // gpio settings of one port slice
    typedef struct packed {
        logic [3:0] dir;
        logic [3:0] data;
    } esm_gpio_t;
endpackage

// >>> tb_top.sv
// testbench for the encoder and spi pin multiplexer
`timescale 1ns/1ps
module tb_top;
    import esm_pkg::*;
    logic clk = 0, sys_rst = 1, pur_write = 0, spi0_master = 0, sclk_o = 0, mosi_o = 0;
    logic [1:0] portc_mode_sel = ESM_CMODE_QDEC, porte_gpio_sel = '0, e_en = '0, e_val = '0;
    logic [3:0] portc_gpio_sel = '0, c_en = '0, c_val = '0;
    logic [7:0] pc_w = 8'hF0, pe_w = 8'h30;
    esm_gpio_t portc_gpio = '0, porte_gpio = '0;
    esm_pad_t [3:0] timer_a_chan = 12'hFFF;
    wire [3:0] pc_in, pc_out, pc_oe_n, pc_pu, tmr_in, pc_gin, dec;
    wire [1:0] pe_in, pe_out, pe_oe_n, pe_pu, pe_gin, spi;
    int err_count = 0, comparisons = 0;
    initial forever #12.5 clk = ~clk;
    esm_pin_mux i_dut (.clk(clk), .sys_rst(sys_rst), .portc_mode_sel(portc_mode_sel),
        .portc_gpio_sel(portc_gpio_sel), .porte_gpio_sel(porte_gpio_sel), .pur_write(pur_write),
        .portc_pullup_enable_wdata(pc_w), .porte_pullup_enable_wdata(pe_w), .portc_gpio(portc_gpio),
        .porte_gpio(porte_gpio), .spi0_master(spi0_master), .portc_pad_in(pc_in), .porte_pad_in(pe_in),
        .portc_pad_out(pc_out), .portc_pad_oe_n(pc_oe_n), .portc_pad_pullup(pc_pu), .porte_pad_out(pe_out),
        .porte_pad_oe_n(pe_oe_n), .porte_pad_pullup(pe_pu), .decoder0_phase_a(dec[0]),
        .decoder0_phase_b(dec[1]), .decoder0_index_pulse(dec[2]), .decoder0_home_switch(dec[3]),
        .timer_a_chan(timer_a_chan), .timer_a_in(tmr_in), .spi0_clock_out(sclk_o), .spi0_mosi_out(mosi_o),
        .spi0_serial_clock(spi[0]), .spi0_master_out_line(spi[1]), .portc_gpio_in(pc_gin),
        .porte_gpio_in(pe_gin));
    esm_pad_partner #(.N(4)) i_pc (.clk(clk), .pad_out(pc_out), .pad_oe_n(pc_oe_n), .pad_pullup(pc_pu),
        .ext_en(c_en), .ext_val(c_val), .pad_in(pc_in));
    esm_pad_partner #(.N(2)) i_pe (.clk(clk), .pad_out(pe_out), .pad_oe_n(pe_oe_n), .pad_pullup(pe_pu),
        .ext_en(e_en), .ext_val(e_val), .pad_in(pe_in));
    // ========================================
    // helpers
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    // a setting reaches the pad in two edges and loops back in three more, one spare
    task automatic settle();
        repeat (6) @(negedge clk);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ========================================
    // scenarios
    task automatic t_reset();
        c_en = '1;
        c_val = 4'b1001;
        e_en = '1;
        e_val = 2'b10;
        settle();
        chk("c oe_n", pc_oe_n, 4'hF);
        chk("pullups", {pc_pu, pe_pu}, 8'h3F);
        chk("decoder", dec, 4'b1001);
        chk("spi slave", spi, 2'b10);
        c_val = 4'b0110;
        settle();
        chk("decoder", dec, 4'b0110);
    endtask
    task automatic t_pullup();
        pc_w = 8'hA0;
        pe_w = 8'h10;
        pur_write = 1;
        @(negedge clk);
        pur_write = 0;
        settle();
        chk("c pullup", pc_pu, 4'b1010);
        chk("e pullup", pe_pu, 2'b01);
    endtask
    task automatic t_timer();
        portc_mode_sel = ESM_CMODE_TMR;
        portc_gpio = 8'hF0;
        timer_a_chan = {3'b001, 3'b001, 3'b000, 3'b010};
        c_en = 4'b1100;
        c_val = 4'b0100;
        settle();
        chk("timer oe_n", pc_oe_n, 4'b1100);
        chk("timer out", pc_out[1:0], 2'b01);
        chk("timer in", tmr_in, 4'b0101);
        chk("decoder off", dec, 4'h0);
    endtask
    task automatic t_gpio();
        portc_gpio_sel = '1;
        portc_gpio = 8'h53;
        c_en = 4'b1010;
        c_val = 4'b1000;
        settle();
        chk("gpio oe_n", pc_oe_n, 4'b1010);
        chk("gpio out", pc_out & 4'b0101, 4'b0001);
        chk("gpio in", pc_gin, 4'b1001);
        chk("timer off", tmr_in, 4'h0);
    endtask
    task automatic t_master();
        spi0_master = 1;
        sclk_o = 1;
        e_en = '0;
        settle();
        chk("master oe_n", pe_oe_n, 2'b00);
        chk("master out", pe_out, 2'b01);
        chk("master loop", spi, 2'b01);
        sclk_o = 0;
        mosi_o = 1;
        settle();
        chk("master out", pe_out, 2'b10);
        chk("master loop", spi, 2'b10);
        porte_gpio_sel = 2'b11;
        porte_gpio = 8'h22;
        settle();
        chk("e gpio oe_n", pe_oe_n, 2'b01);
        chk("spi off", spi, 2'b00);
        chk("e gpio out", pe_out, 2'b10);
        chk("e gpio in", pe_gin, 2'b11);
    endtask
    // reset in mid-run floats all pads, clears the spi lines and brings back the pull-ups
    task automatic t_rerst();
        sys_rst = 1;
        repeat (2) @(negedge clk);
        chk("reset oe_n", {pc_oe_n, pe_oe_n}, 8'h3F);
        chk("reset pullups", {pc_pu, pe_pu}, 8'h3F);
        chk("reset spi", spi, 2'b00);
        sys_rst = 0;
        settle();
    endtask
    initial begin
        repeat (10) @(negedge clk);
        sys_rst = 0;
        t_reset();
        t_pullup();
        t_timer();
        t_gpio();
        t_master();
        t_rerst();
        tally_and_finish();
    end
    initial begin
        #20000;
        err_count++;
        tally_and_finish();
    end
endmodule
